// File: design/cam_switch_pkg.sv
// Constants, register map and encodings of the weekly cam time switch
// Overview of operation
// [RQ1] Three independent cams, each one time window.
// [RQ2] Enabled on-time match drives output high.
// [RQ3] Enabled off-time match drives output low.
// [RQ4] Higher-numbered cam wins a same-instant conflict.
// [RQ5] Seven day flags gate each cam's switching.
// [RQ6] Days Monday first; letter selected, dash unselected.
// [RQ7] Times are hour:minute from 00:00 to 23:59.
// [RQ8] Blank time value causes no switching action.
// [RQ9] Compare once per minute change, act once.
package cam_switch_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_CAMS      = 3;
    localparam int DAYS_PER_WEEK = 7;
    localparam int ADDR_W        = 8;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] CAM_REGION_END = 8'h30;
    localparam int         CAM_IDX_LSB    = 4;
    localparam int         SLOT_LSB       = 2;
    localparam logic [1:0] SLOT_DAYS      = 2'h0;
    localparam logic [1:0] SLOT_ON        = 2'h1;
    localparam logic [1:0] SLOT_OFF       = 2'h2;
    localparam logic [7:0] STATUS_ADDR    = 8'h30;
    localparam logic [7:0] TEXT_SEL_ADDR  = 8'h34;
    localparam logic [7:0] TEXT_LO_ADDR   = 8'h38;
    localparam logic [7:0] TEXT_HI_ADDR   = 8'h3c;

    // ----------------------------------------------------------------
    // Time field layout
    // ----------------------------------------------------------------
    localparam int         MIN_LSB   = 0;
    localparam int         MIN_W     = 6;
    localparam int         HOUR_LSB  = 8;
    localparam int         HOUR_W    = 5;
    localparam int         BLANK_BIT = 15;
    localparam logic [4:0] MAX_HOUR  = 5'h17;
    localparam logic [5:0] MAX_MIN   = 6'h3b;

    // ----------------------------------------------------------------
    // Status field layout
    // ----------------------------------------------------------------
    localparam int STAT_OUT_BIT  = 0;
    localparam int STAT_DAY_LSB  = 8;
    localparam int STAT_HOUR_LSB = 16;
    localparam int STAT_MIN_LSB  = 24;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] TIME_RESET = 16'h8000;
    localparam logic [6:0]  DAYS_RESET = 7'h00;
    localparam logic [1:0]  SEL_RESET  = 2'h0;

    // ----------------------------------------------------------------
    // Day letters, index 0 is Monday
    // ----------------------------------------------------------------
    localparam logic [6:0][7:0] DAY_LETTERS = {8'h53, 8'h53, 8'h46, 8'h54, 8'h57, 8'h54, 8'h4d};
    localparam logic [7:0]      DAY_DASH    = 8'h2d;

    // ----------------------------------------------------------------
    // Bus responses and channel states
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic {WR_IDLE, WR_RESP} wr_state_t;
    typedef enum logic {RD_IDLE, RD_DATA} rd_state_t;

endpackage : cam_switch_pkg

// File: design/cam_matcher.sv
// One cam: compares its day mask and times with the current calendar time
`timescale 1ns/1ps
module cam_matcher
    import cam_switch_pkg::*;
(
    input  wire logic [6:0]  day_mask,
    input  wire logic [15:0] on_time,
    input  wire logic [15:0] off_time,
    input  wire logic [2:0]  weekday,
    input  wire logic [4:0]  hour,
    input  wire logic [5:0]  minute,
    input  wire logic        minute_step,
    output logic             on_hit,
    output logic             off_hit
);

    logic day_ok;
    logic on_eq;
    logic off_eq;

    // ----------------------------------------------------------------
    // Match logic
    // ----------------------------------------------------------------
    always_comb begin
        day_ok = 1'b0;
        if (weekday < 3'(DAYS_PER_WEEK)) begin
            day_ok = day_mask[weekday]; // see [RQ5]
        end
        on_eq  = !on_time[BLANK_BIT] // see [RQ8]
                 && on_time[HOUR_LSB +: HOUR_W] == hour
                 && on_time[MIN_LSB +: MIN_W] == minute;
        off_eq = !off_time[BLANK_BIT] // see [RQ8]
                 && off_time[HOUR_LSB +: HOUR_W] == hour
                 && off_time[MIN_LSB +: MIN_W] == minute;
        on_hit  = minute_step && day_ok && on_eq; // see [RQ9]
        off_hit = minute_step && day_ok && off_eq; // see [RQ9]
    end

endmodule : cam_matcher

// File: design/cam_time_switch.sv
// Weekly three-cam time switch with an AXI4-Lite register slave
//
// Chosen here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module cam_time_switch
    import cam_switch_pkg::*;
(
    input  wire logic              sys_clk,
    input  wire logic              reset_n,
    // Calendar time base
    input  wire logic              cal_tick,
    input  wire logic [2:0]        cal_weekday,
    input  wire logic [4:0]        cal_hour,
    input  wire logic [5:0]        cal_minute,
    // Switched output
    output logic                   switch_out,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready
);

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    // Cam settings, switch level and bus channel state
    // Times: blank in bit 15, hour in 12:8, minute in 5:0
    typedef struct packed {
        logic [NUM_CAMS-1:0][6:0]  days;
        logic [NUM_CAMS-1:0][15:0] on_time;
        logic [NUM_CAMS-1:0][15:0] off_time;
        logic                      out;
        logic                      tick_prev;
        logic [1:0]                text_sel;
        wr_state_t                 wr_state;
        logic                      aw_held;
        logic                      w_held;
        logic [ADDR_W-1:0]         aw_addr;
        logic [31:0]               w_data;
        logic [3:0]                w_strb;
        logic [1:0]                bresp;
        rd_state_t                 rd_state;
        logic [31:0]               rdata;
        logic [1:0]                rresp;
    } state_t;

    state_t                st_reg;
    state_t                st_next;
    logic                  minute_step;
    logic [NUM_CAMS-1:0]   on_hit;
    logic [NUM_CAMS-1:0]   off_hit;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Seven display characters, Monday in the lowest byte
    function automatic logic [55:0] day_text(input logic [6:0] mask);
        logic [55:0] txt;
        txt = '0;
        for (int i = 0; i < DAYS_PER_WEEK; i++) begin
            txt[8*i +: 8] = mask[i] ? DAY_LETTERS[i] : DAY_DASH; // see [RQ6]
        end
        return txt;
    endfunction : day_text

    // Out-of-range or blank times are stored as the blank value
    function automatic logic [15:0] clean_time(input logic [15:0] t);
        logic [15:0] r;
        r = TIME_RESET;
        if (!t[BLANK_BIT]
            && t[HOUR_LSB +: HOUR_W] <= MAX_HOUR
            && t[MIN_LSB +: MIN_W] <= MAX_MIN) begin // see [RQ7]
            r = '0;
            r[HOUR_LSB +: HOUR_W] = t[HOUR_LSB +: HOUR_W];
            r[MIN_LSB +: MIN_W]   = t[MIN_LSB +: MIN_W];
        end
        return r;
    endfunction : clean_time

    // Read decode: bit 32 flags an unmapped address
    // Shared by the read path and the write merge
    function automatic logic [32:0] read_reg(input logic [ADDR_W-1:0] addr, input state_t s);
        logic [32:0] r;
        logic [1:0]  cam;
        logic [55:0] txt;
        r   = '0;
        cam = addr[CAM_IDX_LSB +: 2];
        // A selector past the last cam shows only dashes
        txt = {7{DAY_DASH}};
        if (s.text_sel < 2'(NUM_CAMS)) begin
            txt = day_text(s.days[s.text_sel]);
        end
        if (addr[1:0] != 2'h0) begin
            r[32] = 1'b1;
        end else if (addr < CAM_REGION_END) begin
            case (addr[SLOT_LSB +: 2])
                SLOT_DAYS: r[6:0]  = s.days[cam];
                SLOT_ON:   r[15:0] = s.on_time[cam];
                SLOT_OFF:  r[15:0] = s.off_time[cam];
                default:   r[32]   = 1'b1;
            endcase
        end else begin
            case (addr)
                // Live calendar inputs, not a snapshot
                STATUS_ADDR: begin
                    r[STAT_OUT_BIT]            = s.out;
                    r[STAT_DAY_LSB +: 3]       = cal_weekday;
                    r[STAT_HOUR_LSB +: HOUR_W] = cal_hour;
                    r[STAT_MIN_LSB +: MIN_W]   = cal_minute;
                end
                TEXT_SEL_ADDR: r[1:0]  = s.text_sel;
                TEXT_LO_ADDR:  r[31:0] = txt[31:0];
                TEXT_HI_ADDR:  r[23:0] = txt[55:32];
                default:       r[32]   = 1'b1;
            endcase
        end
        return r;
    endfunction : read_reg

    // ----------------------------------------------------------------
    // Cam comparators
    // ----------------------------------------------------------------
    // Only the rise counts: a strobe held high
    // over several minutes switches at most once
    assign minute_step = cal_tick && !st_reg.tick_prev; // see [RQ9]

    // One comparator per cam on the shared calendar inputs
    for (genvar g = 0; g < NUM_CAMS; g++) begin : g_cam // see [RQ1]
        cam_matcher u_cam (
            .day_mask    (st_reg.days[g]),
            .on_time     (st_reg.on_time[g]),
            .off_time    (st_reg.off_time[g]),
            .weekday     (cal_weekday),
            .hour        (cal_hour),
            .minute      (cal_minute),
            .minute_step (minute_step),
            .on_hit      (on_hit[g]),
            .off_hit     (off_hit[g])
        );
    end

    // ----------------------------------------------------------------
    // Handshake outputs
    // ----------------------------------------------------------------
    // A channel refuses a second beat while one is held
    // or a response waits; reads never wait on writes
    assign s_axi_awready = (st_reg.wr_state == WR_IDLE) && !st_reg.aw_held;
    assign s_axi_wready  = (st_reg.wr_state == WR_IDLE) && !st_reg.w_held;
    assign s_axi_bvalid  = (st_reg.wr_state == WR_RESP);
    assign s_axi_bresp   = st_reg.bresp;
    assign s_axi_arready = (st_reg.rd_state == RD_IDLE);
    assign s_axi_rvalid  = (st_reg.rd_state == RD_DATA);
    assign s_axi_rdata   = st_reg.rdata;
    assign s_axi_rresp   = st_reg.rresp;
    // Switch level straight from its flip-flop
    assign switch_out    = st_reg.out;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        // Locals for the write merge and the read decode
        logic              aw_ok;
        logic              w_ok;
        logic [ADDR_W-1:0] waddr;
        logic [31:0]       wdat;
        logic [3:0]        wstb;
        logic [32:0]       cur;
        logic [31:0]       merged;
        logic [1:0]        cam;
        logic [32:0]       rd;
        aw_ok   = 1'b0;
        w_ok    = 1'b0;
        waddr   = '0;
        wdat    = '0;
        wstb    = '0;
        cur     = '0;
        merged  = '0;
        cam     = '0;
        rd      = '0;
        st_next = st_reg;

        // Output switching; later cams override earlier ones
        // Within one cam an off match beats its own on match
        st_next.tick_prev = cal_tick;
        for (int i = 0; i < NUM_CAMS; i++) begin // see [RQ4]
            if (on_hit[i]) begin
                st_next.out = 1'b1; // see [RQ2]
            end
            if (off_hit[i]) begin
                st_next.out = 1'b0; // see [RQ3]
            end
        end

        // Write channel
        // Address and data in either order; the first waits
        // for its partner, then the register is written
        case (st_reg.wr_state)
            WR_IDLE: begin
                aw_ok = st_reg.aw_held || s_axi_awvalid;
                w_ok  = st_reg.w_held || s_axi_wvalid;
                waddr = st_reg.aw_held ? st_reg.aw_addr : s_axi_awaddr;
                wdat  = st_reg.w_held ? st_reg.w_data : s_axi_wdata;
                wstb  = st_reg.w_held ? st_reg.w_strb : s_axi_wstrb;
                if (aw_ok && w_ok) begin
                    cur = read_reg(waddr, st_reg);
                    // Unstrobed byte lanes keep the current contents
                    for (int b = 0; b < 4; b++) begin
                        merged[8*b +: 8] = wstb[b] ? wdat[8*b +: 8] : cur[8*b +: 8];
                    end
                    cam           = waddr[CAM_IDX_LSB +: 2];
                    // Unmapped or unaligned: error answer, no change
                    st_next.bresp = cur[32] ? RESP_SLVERR : RESP_OKAY;
                    // Status and text character registers ignore writes; the text selector is written
                    if (!cur[32] && waddr < CAM_REGION_END) begin
                        case (waddr[SLOT_LSB +: 2])
                            SLOT_DAYS: st_next.days[cam]     = merged[6:0]; // see [RQ5]
                            SLOT_ON:   st_next.on_time[cam]  = clean_time(merged[15:0]);
                            SLOT_OFF:  st_next.off_time[cam] = clean_time(merged[15:0]);
                            default:   st_next.bresp         = RESP_SLVERR;
                        endcase
                    end else if (!cur[32] && waddr == TEXT_SEL_ADDR) begin
                        st_next.text_sel = merged[1:0];
                    end
                    st_next.aw_held  = 1'b0;
                    st_next.w_held   = 1'b0;
                    st_next.wr_state = WR_RESP;
                end else if (aw_ok) begin
                    st_next.aw_held = 1'b1;
                    st_next.aw_addr = waddr;
                end else if (w_ok) begin
                    st_next.w_held = 1'b1;
                    st_next.w_data = wdat;
                    st_next.w_strb = wstb;
                end
            end
            WR_RESP: begin
                // The response stands until the master takes it
                if (s_axi_bready) begin
                    st_next.wr_state = WR_IDLE;
                end
            end
            default: st_next.wr_state = WR_IDLE;
        endcase

        // Read channel
        // Read data are captured as the address is taken
        // and stand until the master takes them
        case (st_reg.rd_state)
            RD_IDLE: begin
                if (s_axi_arvalid) begin
                    rd               = read_reg(s_axi_araddr, st_reg);
                    st_next.rdata    = rd[31:0];
                    st_next.rresp    = rd[32] ? RESP_SLVERR : RESP_OKAY;
                    st_next.rd_state = RD_DATA;
                end
            end
            RD_DATA: begin
                if (s_axi_rready) begin
                    st_next.rd_state = RD_IDLE;
                end
            end
            default: st_next.rd_state = RD_IDLE;
        endcase
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Synchronous reset; cams come up blank, so nothing
    // switches until software sets a cam
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            st_reg           <= '0;
            st_reg.days      <= {NUM_CAMS{DAYS_RESET}};
            st_reg.on_time   <= {NUM_CAMS{TIME_RESET}};
            st_reg.off_time  <= {NUM_CAMS{TIME_RESET}};
            st_reg.text_sel  <= SEL_RESET;
            // Starts high: a strobe already high at release is no step
            st_reg.tick_prev <= 1'b1;
            st_reg.wr_state  <= WR_IDLE;
            st_reg.rd_state  <= RD_IDLE;
            st_reg.bresp     <= RESP_OKAY;
            st_reg.rresp     <= RESP_OKAY;
        end else begin
            st_reg <= st_next;
        end
    end

endmodule : cam_time_switch

// File: verification/cam_time_switch_asserts.sv
// Concurrent checks on the ports of the cam time switch
`timescale 1ns/1ps
module cam_time_switch_asserts
    import cam_switch_pkg::*;
(
    input wire logic              sys_clk,
    input wire logic              reset_n,
    input wire logic              cal_tick,
    input wire logic [2:0]        cal_weekday,
    input wire logic [4:0]        cal_hour,
    input wire logic              switch_out,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    // ----------------------------------------------------------------
    // Bus and calendar steps
    // ----------------------------------------------------------------
    sequence ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence tick_held;
        cal_tick [*3];
    endsequence

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    out_on_step_a: assert property ($changed(switch_out) |-> $past(cal_tick) && !$past(cal_tick, 2))
        else $error("switch output moved without a minute step");
    tick_once_a: assert property (tick_held |=> $stable(switch_out))
        else $error("held minute strobe switched again");
    wr_answer_a: assert property (wr_take |=> s_axi_bvalid)
        else $error("write response late");
    rd_answer_a: assert property (ar_take |=> s_axi_rvalid)
        else $error("read data late");
    wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write channels ready during response");
    rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address ready during data");
    bad_addr_a: assert property (ar_take ##0 (s_axi_araddr[1:0] != 2'h0)
        |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unaligned read not refused");
    status_live_a: assert property (ar_take ##0 (s_axi_araddr == STATUS_ADDR)
        |=> s_axi_rdata[10:8] == $past(cal_weekday) && s_axi_rdata[20:16] == $past(cal_hour))
        else $error("status fields differ from calendar");
endmodule : cam_time_switch_asserts

// File: verification/cam_time_switch_tb_top.sv
// Self-checking bench for the weekly cam time switch
`timescale 1ns/1ps
module cam_time_switch_tb_top;
    import cam_switch_pkg::*;
    logic              sys_clk, reset_n, cal_tick, switch_out;
    logic [2:0]        cal_weekday;
    logic [4:0]        cal_hour;
    logic [5:0]        cal_minute;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic              awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready;
    logic [31:0]       wdata, rdata;
    logic [3:0]        wstrb;
    logic [1:0]        bresp, rresp;
    int                error_cnt = 0;
    int                compares = 0;

    cam_time_switch u_cam_time_switch (
        .sys_clk(sys_clk), .reset_n(reset_n), .cal_tick(cal_tick), .cal_weekday(cal_weekday),
        .cal_hour(cal_hour), .cal_minute(cal_minute), .switch_out(switch_out),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    always #5 sys_clk = ~sys_clk;

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic end_sim;
        if (error_cnt == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk

    task automatic fail_wait(input string msg);
        error_cnt++;
        $display("ERROR %0t: %s timed out", $time, msg);
        end_sim();
    endtask : fail_wait

    function automatic logic [31:0] tm(input int h, input int m);
        return {16'h0, 3'h0, h[4:0], 2'h0, m[5:0]};
    endfunction : tm

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        bit done;
        done = 1'b0;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        repeat (20) begin
            @(posedge sys_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                chk({30'h0, bresp}, {30'h0, er}, "bresp");
                bready <= 1'b0;
                done = 1'b1;
                break;
            end
        end
        if (!done) fail_wait("write");
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        bit done;
        done = 1'b0;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        repeat (20) begin
            @(posedge sys_clk);
            if (arready) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                chk(rdata, ed, "rdata");
                chk({30'h0, rresp}, {30'h0, er}, "rresp");
                rready <= 1'b0;
                done = 1'b1;
                break;
            end
        end
        if (!done) fail_wait("read");
    endtask : rd

    // One minute step at the given day and time, then the output level
    task automatic tk(input logic [2:0] d, input logic [4:0] h, input logic [5:0] m, input logic e);
        @(posedge sys_clk);
        cal_weekday <= d;
        cal_hour <= h;
        cal_minute <= m;
        cal_tick <= 1'b1;
        @(posedge sys_clk);
        cal_tick <= 1'b0;
        repeat (2) @(posedge sys_clk);
        chk({31'h0, switch_out}, {31'h0, e}, "switch_out");
    endtask : tk

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        reset_n = 1'b0;
        {cal_tick, cal_weekday, cal_hour, cal_minute} = '0;
        {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
        wstrb = 4'hf;
        repeat (10) @(posedge sys_clk);
        reset_n <= 1'b1;
        for (int i = 0; i < NUM_CAMS; i++) begin
            rd(8'(16 * i), 32'h0, RESP_OKAY);
            rd(8'(16 * i + 4), {16'h0, TIME_RESET}, RESP_OKAY);
            rd(8'(16 * i + 8), {16'h0, TIME_RESET}, RESP_OKAY);
        end
        rd(8'h0c, 32'h0, RESP_SLVERR);
        rd(8'h02, 32'h0, RESP_SLVERR);
        wr(8'h1c, 32'h1, RESP_SLVERR);
        wr(STATUS_ADDR, 32'hffff_ffff, RESP_OKAY);
        wr(8'h04, tm(24, 0), RESP_OKAY);
        rd(8'h04, 32'h8000, RESP_OKAY);
        wr(8'h04, tm(12, 60), RESP_OKAY);
        rd(8'h04, 32'h8000, RESP_OKAY);
        wr(8'h04, tm(23, 59), RESP_OKAY);
        rd(8'h04, tm(23, 59), RESP_OKAY);
        wr(8'h00, 32'h7f, RESP_OKAY);
        wr(8'h04, tm(5, 30), RESP_OKAY);
        wr(8'h08, tm(7, 40), RESP_OKAY);
        wr(8'h10, 32'h02, RESP_OKAY);
        wr(8'h14, tm(7, 40), RESP_OKAY);
        wr(8'h18, tm(9, 0), RESP_OKAY);
        wr(8'h20, 32'h62, RESP_OKAY);
        wr(8'h24, tm(9, 0), RESP_OKAY);
        wr(8'h28, tm(12, 0), RESP_OKAY);
        tk(0, 5, 29, 1'b0);
        tk(0, 5, 30, 1'b1);
        tk(0, 5, 30, 1'b1);
        tk(0, 7, 40, 1'b0);
        tk(0, 7, 40, 1'b0);
        tk(1, 7, 40, 1'b1);
        tk(1, 12, 0, 1'b0);
        tk(1, 9, 0, 1'b1);
        tk(0, 12, 0, 1'b1);
        tk(1, 12, 0, 1'b0);
        tk(7, 5, 30, 1'b0);
        // Strobe held high across a matching minute must not switch
        @(posedge sys_clk);
        {cal_weekday, cal_hour, cal_minute} <= {3'h0, 5'h05, 6'h1d};
        cal_tick <= 1'b1;
        repeat (3) @(posedge sys_clk);
        cal_minute <= 6'h1e;
        repeat (4) @(posedge sys_clk);
        chk({31'h0, switch_out}, 32'h0, "held strobe");
        cal_tick <= 1'b0;
        tk(0, 5, 30, 1'b1);
        wr(8'h08, 32'h8000, RESP_OKAY);
        tk(3, 7, 40, 1'b1);
        rd(STATUS_ADDR, {2'h0, 6'd40, 3'h0, 5'd7, 5'h0, 3'd3, 7'h0, 1'b1}, RESP_OKAY);
        wr(TEXT_SEL_ADDR, 32'h1, RESP_OKAY);
        rd(TEXT_SEL_ADDR, 32'h1, RESP_OKAY);
        rd(TEXT_LO_ADDR, 32'h2d2d542d, RESP_OKAY);
        rd(TEXT_HI_ADDR, 32'h002d2d2d, RESP_OKAY);
        wr(TEXT_SEL_ADDR, 32'h0, RESP_OKAY);
        rd(TEXT_LO_ADDR, 32'h5457544d, RESP_OKAY);
        rd(TEXT_HI_ADDR, 32'h00535346, RESP_OKAY);
        wr(TEXT_SEL_ADDR, 32'h2, RESP_OKAY);
        rd(TEXT_HI_ADDR, 32'h0053532d, RESP_OKAY);
        wr(TEXT_SEL_ADDR, 32'h3, RESP_OKAY);
        rd(TEXT_LO_ADDR, 32'h2d2d2d2d, RESP_OKAY);
        rd(TEXT_HI_ADDR, 32'h002d2d2d, RESP_OKAY);
        // Byte-lane merge: only the hour byte of the second cam's on time
        wstrb <= 4'h2;
        wr(8'h14, 32'h0000_0b00, RESP_OKAY);
        rd(8'h14, tm(11, 40), RESP_OKAY);
        end_sim();
    end
endmodule : cam_time_switch_tb_top

bind cam_time_switch cam_time_switch_asserts u_cam_time_switch_asserts (
    .sys_clk(sys_clk), .reset_n(reset_n), .cal_tick(cal_tick), .cal_weekday(cal_weekday),
    .cal_hour(cal_hour), .switch_out(switch_out), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid)
);
